// ---- ser_status.sv ----
`timescale 1ns/10ps
// Behaviour
// - set bit 0 when all commands through an operation-complete command finish
// - set bit 2 on empty read, unread query overrun, or both buffers full
// - set bit 3 on self-test failure, calibration failure or reading overload
// - set bit 4 when a command fails during execution
// - set bit 5 on a command syntax error
// - set bit 7 after power cycle until queried or cleared
// - error events on bits 2 to 5 push an error queue entry, overloads excepted
// - overload sets bit 3 and matching quality bit, no queue entry
// - masked OR of standard events forms status byte bit 5
// - clear-status or standard event read clears standard event latch
// - standard mask cleared by zero write, or power-on if clear setting is 1
// - quality bit 0 on voltage-type overload, bit 1 on current overload
// - quality bit 9 on two or four wire resistance overload
// - limit test sets bit 11 below low limit, bit 12 above high
// - masked OR of quality events forms the quality summary bit
// - clear-status or quality event read clears quality latch
// - quality mask cleared at every power-on, on preset, and zero write
// - message available rises at first trigger, falls when buffer fully read
// - armed readings raise message available only after all are transferred
// - output buffer full before pending completion command stops readings
// - event bits latch until cleared; reset and device clear leave them
module ser_status
    import ser_pkg::*;
(
    // system; rst is the power-on event
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // non-volatile power-on clear setting
    input wire logic psc_setting,
    // command decoder strobes
    input wire logic cls_cmd,
    input wire logic esr_query,
    input wire logic ese_write,
    input wire logic [7:0] ese_value,
    input wire logic ques_event_query,
    input wire logic ques_enable_write,
    input wire logic [15:0] ques_enable_value,
    input wire logic status_preset,
    input wire logic opc_done,
    // error sources
    input wire logic query_empty_read,
    input wire logic query_interrupted,
    input wire logic query_deadlock,
    input wire logic selftest_fail,
    input wire logic cal_fail,
    input wire logic exec_error,
    input wire logic syntax_error,
    input wire logic [4:0] exec_code,
    // measurement sources
    input wire logic ovl_valid,
    input wire ser_ovl_t ovl_kind,
    input wire logic limit_lo_fail,
    input wire logic limit_hi_fail,
    // output buffer and trigger
    input wire logic first_trigger,
    input wire logic armed_mode,
    input wire logic armed_all_xfer,
    input wire logic out_buf_empty,
    input wire logic out_buf_full,
    input wire logic opc_pending,
    // register views
    output logic [7:0] std_event_latch,
    output logic [7:0] std_event_mask,
    output logic [15:0] qual_event_latch,
    output logic [15:0] qual_event_mask,
    output logic [7:0] status_summary,
    // error queue push and reading stall
    output logic err_push,
    output logic [2:0] err_kind,
    output logic reading_stall
);
    ser_evt_if #(.W(8)) se_if ();
    ser_evt_if #(.W(16)) qe_if ();

    logic [7:0] standard_event_mask;
    logic [7:0] next_standard_event_mask;
    logic [15:0] quality_event_mask;
    logic [15:0] next_quality_event_mask;
    logic mav;
    logic next_mav;
    logic [7:0] pon_mask;
    logic next_err_push;
    logic [2:0] next_err_kind;
    logic next_stall;
    logic [7:0] se_set;
    logic [15:0] qe_set;

    // ==========================================
    // event sources
    always_comb
    begin
        se_set = '0;
        se_set[SE_OPC] = opc_done;
        se_set[SE_QUERY] = query_empty_read | query_interrupted | query_deadlock;
        se_set[SE_DEVICE] = selftest_fail | cal_fail | (ovl_valid && ovl_kind != SER_OVL_NONE);
        se_set[SE_EXEC] = exec_error;
        se_set[SE_CMD] = syntax_error;
        qe_set = '0;
        qe_set[QE_VOLT] = ovl_valid && ovl_kind == SER_OVL_VOLT;
        qe_set[QE_CURR] = ovl_valid && ovl_kind == SER_OVL_CURR;
        qe_set[QE_OHMS] = ovl_valid && ovl_kind == SER_OVL_OHMS;
        qe_set[QE_LIM_LO] = limit_lo_fail;
        qe_set[QE_LIM_HI] = limit_hi_fail;
    end

    assign se_if.set_bits = se_set;
    assign se_if.clear = cls_cmd | esr_query;
    // summaries use the mask of the same edge, so a mask write shows at once
    assign se_if.mask = rst ? pon_mask : next_standard_event_mask;
    assign qe_if.set_bits = qe_set;
    assign qe_if.clear = cls_cmd | ques_event_query;
    assign qe_if.mask = rst ? QE_MASK_RST : next_quality_event_mask;

    // power-on bit starts set through the reset value
    ser_evt_group #(.W(8), .USED(SE_USED), .RST_VAL(SE_LATCH_RST)) u_std (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .g(se_if)
    );

    ser_evt_group #(.W(16), .USED(QE_USED), .RST_VAL(QE_LATCH_RST)) u_qual (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .g(qe_if)
    );

    // ==========================================
    // masks, message available, error queue, stall
    always_comb
    begin
        next_standard_event_mask = standard_event_mask;
        next_quality_event_mask = quality_event_mask;
        // power-on keeps the standard mask unless the stored clear setting is on;
        // with the setting off the very first power-on leaves the mask undefined
        pon_mask = psc_setting ? SE_MASK_RST : standard_event_mask;
        if (ese_write)
        begin
            next_standard_event_mask = ese_value & SE_USED;
        end
        if (status_preset)
        begin
            next_quality_event_mask = QE_MASK_RST;
        end
        else if (ques_enable_write)
        begin
            next_quality_event_mask = ques_enable_value & QE_USED;
        end
        // set wins over the clear of the read-out
        next_mav = mav;
        if (out_buf_empty)
        begin
            next_mav = 1'b0;
        end
        if (armed_mode ? armed_all_xfer : first_trigger)
        begin
            next_mav = 1'b1;
        end
        // overloads never reach the error queue
        next_err_push = query_empty_read | query_interrupted | query_deadlock
            | selftest_fail | cal_fail | exec_error | syntax_error;
        next_err_kind = 3'h0;
        if (syntax_error)
        begin
            next_err_kind = 3'h5;
        end
        else if (exec_error)
        begin
            next_err_kind = 3'h4;
        end
        else if (selftest_fail | cal_fail)
        begin
            next_err_kind = 3'h3;
        end
        else if (next_err_push)
        begin
            next_err_kind = 3'h2;
        end
        next_stall = out_buf_full && opc_pending;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            // the quality mask always clears at power-on
            standard_event_mask <= pon_mask;
            quality_event_mask <= QE_MASK_RST;
            mav <= 1'b0;
            err_push <= 1'b0;
            err_kind <= 3'h0;
            reading_stall <= 1'b0;
        end
        else if (ce)
        begin
            standard_event_mask <= next_standard_event_mask;
            quality_event_mask <= next_quality_event_mask;
            mav <= next_mav;
            err_push <= next_err_push;
            err_kind <= next_err_kind;
            reading_stall <= next_stall;
        end
    end

    // ==========================================
    // register views; latches and summaries are flops in the group
    assign std_event_latch = se_if.latch;
    assign qual_event_latch = qe_if.latch;
    assign std_event_mask = standard_event_mask;
    assign qual_event_mask = quality_event_mask;
    assign status_summary = {2'b00, se_if.summary, mav, qe_if.summary, 3'b000};

    // exec_code reserved for queue detail, kept for decoder compatibility
    logic unused_code;
    assign unused_code = ^exec_code;
endmodule

// ---- ser_pkg.sv ----
package ser_pkg;

    // ==========================================
    // standard event bit positions
    localparam int SE_OPC = 0;
    localparam int SE_QUERY = 2;
    localparam int SE_DEVICE = 3;
    localparam int SE_EXEC = 4;
    localparam int SE_CMD = 5;
    localparam int SE_PON = 7;
    localparam logic [7:0] SE_USED = 8'hBD;

    // ==========================================
    // questionable bit positions
    localparam int QE_VOLT = 0;
    localparam int QE_CURR = 1;
    localparam int QE_OHMS = 9;
    localparam int QE_LIM_LO = 11;
    localparam int QE_LIM_HI = 12;
    localparam logic [15:0] QE_USED = 16'h1A03;

    // ==========================================
    // status byte positions
    localparam int SB_QUES = 3;
    localparam int SB_MAV = 4;
    localparam int SB_ESB = 5;

    // ==========================================
    // reset values
    localparam logic [7:0] SE_LATCH_RST = 8'h80;
    localparam logic [15:0] QE_LATCH_RST = 16'h0000;
    localparam logic [7:0] SE_MASK_RST = 8'h00;
    localparam logic [15:0] QE_MASK_RST = 16'h0000;

    // ==========================================
    // overload source
    typedef enum logic [1:0] {SER_OVL_NONE, SER_OVL_VOLT, SER_OVL_CURR, SER_OVL_OHMS} ser_ovl_t;

endpackage

// ---- ser_evt_if.sv ----
`timescale 1ns/10ps
interface ser_evt_if #(parameter int W = 8);
    logic [W-1:0] set_bits;
    logic clear;
    logic [W-1:0] mask;
    logic [W-1:0] latch;
    logic summary;
    modport owner (output set_bits, output clear, output mask, input latch, input summary);
    modport group (input set_bits, input clear, input mask, output latch, output summary);
endinterface

// ---- ser_evt_group.sv ----
`timescale 1ns/10ps
module ser_evt_group #(
    parameter int W = 8,
    parameter logic [W-1:0] USED = '1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // system
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // group port
    ser_evt_if.group g
);
    logic [W-1:0] latch;
    logic [W-1:0] next_latch;
    logic summary;
    logic next_summary;

    // ==========================================
    // latch: set beats clear so no event is lost
    always_comb
    begin
        next_latch = g.clear ? '0 : latch;
        next_latch = (next_latch | g.set_bits) & USED;
        next_summary = |(next_latch & g.mask & USED);
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            latch <= RST_VAL;
            // a mask kept over power-on must already see the power-on bit
            summary <= |(RST_VAL & g.mask & USED);
        end
        else if (ce)
        begin
            latch <= next_latch;
            summary <= next_summary;
        end
    end

    assign g.latch = latch;
    assign g.summary = summary;
endmodule

// ---- ser_status_properties.sv ----
`timescale 1ns/10ps
module ser_status_chk
    import ser_pkg::*;
(
    // system
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // requests
    input wire logic cls_cmd,
    input wire logic esr_query,
    input wire logic syntax_error,
    input wire logic status_preset,
    input wire logic ovl_valid,
    input wire ser_ovl_t ovl_kind,
    input wire logic out_buf_full,
    input wire logic opc_pending,
    // results
    input wire logic [7:0] std_event_latch,
    input wire logic [7:0] std_event_mask,
    input wire logic [15:0] qual_event_latch,
    input wire logic [15:0] qual_event_mask,
    input wire logic [7:0] status_summary,
    input wire logic err_push,
    input wire logic reading_stall
);
    // ==========================================
    // properties
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    cmd_err_a: assert property (ce && syntax_error |=> std_event_latch[5] && err_push)
        else $error("syntax error not reported");
    ohms_ovl_a: assert property (ce && ovl_valid && ovl_kind == SER_OVL_OHMS |=>
        qual_event_latch[9] && std_event_latch[3]) else $error("ohms overload lost");
    std_sum_a: assert property (status_summary[5] == |(std_event_latch & std_event_mask))
        else $error("standard summary wrong");
    qual_sum_a: assert property (status_summary[3] == |(qual_event_latch & qual_event_mask))
        else $error("quality summary wrong");
    unused_zero_a: assert property (!(std_event_latch & ~SE_USED) && !(std_event_mask & ~SE_USED)
        && !(qual_event_latch & ~QE_USED) && !(qual_event_mask & ~QE_USED)) else $error("unused bit set");
    latch_hold_a: assert property (!rst && !cls_cmd && !esr_query |=>
        (std_event_latch & $past(std_event_latch)) == $past(std_event_latch)) else $error("event lost");
    preset_clr_a: assert property (ce && status_preset |=> qual_event_mask == 16'h0000)
        else $error("preset kept mask");
    stall_set_a: assert property (ce && out_buf_full && opc_pending |=> reading_stall)
        else $error("no reading stall");
endmodule

bind ser_status ser_status_chk i_chk (.*);

// ---- ser_ctrl_model.sv ----
`timescale 1ns/10ps
module ser_ctrl_model (
    // system
    input wire logic clk,
    input wire logic start,
    input wire logic [7:0] status_summary,
    // commands
    output logic cls_cmd,
    output logic ese_write,
    output logic [7:0] ese_value,
    output logic opc_done,
    output logic done
);
    // ==========================================
    // completion sequence; the poll is bounded so a dead summary shows as not done
    initial
    begin
        {cls_cmd, ese_write, ese_value, opc_done, done} = '0;
        wait (start);
        @(posedge clk) cls_cmd <= 1'b1;
        @(posedge clk) {cls_cmd, ese_write, ese_value} <= {2'b01, 8'h01};
        @(posedge clk) {ese_write, opc_done} <= 2'b01;
        @(posedge clk) opc_done <= 1'b0;
        repeat (20) @(posedge clk) if (status_summary[5]) done <= 1'b1;
    end
endmodule

// ---- testbench.sv ----
`timescale 1ns/10ps
`define CHK(n, e, a) checks_done++; if ((a) !== (e)) begin n_fail++; \
    $display("MISMATCH %s exp %h got %h", n, e, a); end
module testbench
    import ser_pkg::*;
;
    typedef struct {int t; int s; logic [15:0] e;} ser_note_t;
    logic clk = 0;
    logic [24:0] pl = 25'h100_0000;
    logic [1:0] kd = '0;
    logic [15:0] vd = '0;
    logic go = 0;
    logic psc = 1'b1;
    logic p_cls, p_ew, p_opc, p_done;
    logic [7:0] p_ev, se_o, sm_o, sb_o, se, sm;
    logic [15:0] qe_o, qm_o, qe, qm;
    logic push_o, stall_o, mav, stall;
    logic [2:0] kind_o;
    logic [15:0] obs [10];
    string nm [10] = '{"se", "qe", "sm", "qm", "sum", "mav", "push", "stall", "kind", "seq"};
    ser_note_t nq [$];
    ser_note_t nt;
    int cyc = 0;
    int n_fail = 0;
    int checks_done = 0;

    always #50 clk = ~clk;
    always_comb obs = '{se_o, qe_o, sm_o, qm_o, sb_o & 8'h28, sb_o[4], push_o, stall_o, kind_o, p_done};

    ser_status i_dut (.clk(clk), .rst(pl[24]), .ce(!pl[23]), .psc_setting(psc),
        .cls_cmd(pl[11] | p_cls), .esr_query(pl[12]), .ese_write(pl[13] | p_ew),
        .ese_value(p_ew ? p_ev : vd[7:0]), .ques_event_query(pl[14]), .ques_enable_write(pl[15]),
        .ques_enable_value(vd), .status_preset(pl[16]), .opc_done(pl[7] | p_opc),
        .query_empty_read(pl[2]), .query_interrupted(pl[3]), .query_deadlock(pl[4]),
        .selftest_fail(pl[5]), .cal_fail(pl[6]), .exec_error(pl[1]), .syntax_error(pl[0]),
        .exec_code(5'h0), .ovl_valid(pl[8]), .ovl_kind(ser_ovl_t'(kd)), .limit_lo_fail(pl[9]),
        .limit_hi_fail(pl[10]), .first_trigger(pl[17]), .armed_mode(pl[19]),
        .armed_all_xfer(pl[18]), .out_buf_empty(pl[20]), .out_buf_full(pl[21]),
        .opc_pending(pl[22]), .std_event_latch(se_o), .std_event_mask(sm_o),
        .qual_event_latch(qe_o), .qual_event_mask(qm_o), .status_summary(sb_o),
        .err_push(push_o), .err_kind(kind_o), .reading_stall(stall_o));
    ser_ctrl_model i_ctrl (.clk(clk), .start(go), .status_summary(sb_o), .cls_cmd(p_cls),
        .ese_write(p_ew), .ese_value(p_ev), .opc_done(p_opc), .done(p_done));

    // ==========================================
    // driver and reference model: p bit 23 freezes, bit 24 is power-on
    task automatic apply(logic [24:0] p, logic [1:0] k = 0, logic [15:0] v = 0);
        logic [7:0] ss;
        logic [15:0] qs;
        logic [3:0] er;
        logic [15:0] ex [8];
        @(posedge clk);
        pl <= p;
        kd <= k;
        vd <= v;
        er = {p[0], p[1], p[5] | p[6], p[2] | p[3] | p[4]};
        ss = {2'b0, er, 1'b0, p[7]} | {4'b0, p[8] && k != 0, 3'b0};
        qs = {3'b0, p[10:9], 1'b0, p[8] && k == 3, 7'b0, p[8] && k == 2, p[8] && k == 1};
        if (p[24])
        begin
            {se, qe, qm, mav, stall} = {SE_LATCH_RST, QE_LATCH_RST, QE_MASK_RST, 2'b0};
            sm = psc ? SE_MASK_RST : sm;
        end
        else if (!p[23])
        begin
            se = (p[11] | p[12] ? 8'h00 : se) | ss;
            qe = (p[11] | p[14] ? 16'h0000 : qe) | qs;
            sm = p[13] ? v[7:0] & SE_USED : sm;
            qm = p[16] ? 16'h0000 : p[15] ? v & QE_USED : qm;
            mav = (p[19] ? p[18] : p[17]) | (mav & !p[20]);
            stall = p[21] & p[22];
        end
        ex = '{se, qe, sm, qm, {2'b0, |(se & sm), 1'b0, |(qe & qm), 3'b0}, mav, |er, stall};
        for (int i = 0; i < 8; i++)
            if (i != 6 || !p[23]) nq.push_back('{cyc + 1, i, ex[i]});
        if ($onehot(er) && !p[23])
            nq.push_back('{cyc + 1, 8, 16'(er[0] ? 2 : er[1] ? 3 : er[2] ? 4 : 5)});
    endtask

    task end_sim();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // ==========================================
    // monitor; the cycle cap also cuts a hang short
    always @(negedge clk)
    begin
        while (nq.size() > 0 && nq[0].t == cyc)
        begin
            nt = nq.pop_front();
            `CHK(nm[nt.s], nt.e, obs[nt.s])
        end
        cyc++;
        if (cyc == 3000)
        begin
            n_fail++;
            end_sim();
        end
    end

    initial
    begin
        void'($urandom(32));
        repeat (5) apply(25'h100_0000);
        apply(0);
        repeat (80) apply(25'($urandom & $urandom & 32'h007F_FFFF), 2'($urandom), 16'($urandom));
        repeat (4) apply(25'h080_0000 | 25'($urandom & 32'h007F_FFFF));
        for (int k = 1; k < 4; k++) apply(25'h000_0100, 2'(k));
        apply(25'h000_2000);
        apply(25'h001_8000, 0, 16'hFFFF);
        apply(25'h000_A000, 0, 16'hFFFF);
        psc <= 1'b0;
        apply(25'h100_0000);
        apply(0);
        psc <= 1'b1;
        apply(25'h100_0000);
        apply(0);
        @(posedge clk) go <= 1'b1;
        for (int i = 0; i < 40 && !p_done; i++) @(posedge clk);
        nq.push_back('{cyc + 1, 9, 16'h0001});
        repeat (2) @(posedge clk);
        end_sim();
    end
endmodule
